/* File: acs_pkg.sv */
/*
 * Package for the conversion sequencer: register map, field positions,
 * reset values, timing constants and the shared types.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package acs_pkg;
    // ========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_HV_AMP_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CONV_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_CONV_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
    // ========================================================
    // Field positions
    localparam int HV_EN_BIT = 7;
    localparam int HV_GAIN_W = 3;
    localparam int DIV_LSB = 3;
    localparam int DIV_W = 5;
    localparam int PGA_W = 3;
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_TM_BIT = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_CM_LSB = 2;
    localparam int CTL_LJST_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int RES_W = 12;
    localparam int JUST_PAD = 4;
    // ========================================================
    // Reset values
    localparam logic [7:0] HV_AMP_RESET = 8'h00;
    localparam logic [7:0] CONV_CONFIG_RESET = 8'hf8;
    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MIN_CONV_PERIOD_NS = 10000;
    localparam int MIN_CONV_CYC = (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] RATE_LOAD = 10'(MIN_CONV_CYC - 1);
    localparam logic [1:0] LP_TRACK_CLKS = 2'h3;
    localparam logic [3:0] SAR_CONV_CLKS = 4'hd;

    typedef enum logic [1:0] {
        CM_SOFTWARE = 2'b00,
        CM_TIMER3 = 2'b01,
        CM_EXT_PIN = 2'b10,
        CM_TIMER2 = 2'b11
    } acs_start_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONVERT = 2'b10
    } acs_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acs_apb_req_type;
endpackage
`default_nettype wire

/* File: acs_sar_tick.sv */
/*
 * Conversion clock divider: one-cycle tick every (divider + 1) system clocks.
 * Assumes the divider value is stable while running.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_sar_tick
    import acs_pkg::*;
(
    input wire logic clk,             // System clock
    input wire logic rst,             // Async reset, high
    input wire logic run,             // Divider enabled
    input wire logic [DIV_W-1:0] div, // Divide value minus one
    output logic tick                 // Conversion clock tick
);
    logic [DIV_W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (!run)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (cnt_ff == div);
            cnt_ff <= (cnt_ff == div) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

/* File: acs_sequencer.sv */
/*
 * Converter sequencer: APB registers, start source selection, tracking
 * modes, busy/done handling, result justification and interrupt.
 * Assumes the converter core presents a stable result at the end of the
 * conversion window and timer overflow pulses on the system clock.
 */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Amplifier control bit7 enables high-voltage amplifier
// - Low gain field selects output amplifier gain
// - Max 100 ksps; clock divided by divider
// - Two-bit field picks one of four starts
// - Writing one to busy starts conversion
// - Timer 3 overflow starts a conversion
// - External pin rising edge starts a conversion
// - Timer 2 overflow starts a conversion
// - Busy reads one throughout each conversion
// - Busy fall sets done flag and interrupt
// - Result left or right justified by bit
// - Default mode tracks whenever not converting
// - Low-power mode tracks three clocks first
// - Low-power pin mode tracks while pin low
// - Tracking stops in chip sleep modes
// - Every conversion yields a 12-bit result
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic CLK_SYS,                 // System clock, 100 MHz
    input wire logic RST,                     // Async reset, high
    input wire acs_pkg::acs_apb_req_type APB_REQ, // APB request
    output logic [31:0] PRDATA,               // APB read data
    output logic PREADY,                      // APB ready
    output logic PSLVERR,                     // APB error, unmapped address
    input wire logic TMR3_OVF,                // Timer 3 overflow pulse
    input wire logic TMR2_OVF,                // Timer 2 overflow pulse
    input wire logic EXT_CONV_START,          // External start pin
    input wire logic CHIP_SLEEP,              // Chip in standby or sleep
    input wire logic [RES_W-1:0] SAR_RESULT,  // Converter core result
    output logic HV_DIFF_AMP_EN,              // High-voltage amplifier on
    output logic [HV_GAIN_W-1:0] HV_GAIN_SEL, // Output amplifier gain code
    output logic [PGA_W-1:0] PGA_GAIN,        // Gain stage code
    output logic SAR_POWER,                   // Converter enabled
    output logic SAR_TRACK,                   // Track-and-hold tracking
    output logic SAR_CONVERT,                 // Converting
    output logic SAR_CLK_TICK,                // Conversion clock tick
    output logic IRQ                          // Interrupt, level high
);
    import acs_pkg::*;

    typedef struct packed {
        logic [7:0] hv_ctrl;
        logic [7:0] cfg;
        logic en;
        logic tm;
        logic done;
        logic [1:0] cm;
        logic ljst;
        acs_state_type st;
        logic [1:0] trk_cnt;
        logic [3:0] cnv_cnt;
        logic [9:0] rate_cnt;
        logic [RES_W-1:0] result;
        logic [2:0] pin_sync;
        logic pin_q;
        logic irq_stat;
        logic irq_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic track;
        logic convert;
        logic sar_tick;
    } acs_regs_type;

    acs_regs_type r_ff;
    acs_regs_type nxt_r;
    logic tick;
    logic busy;
    logic wr_en;
    logic setup;
    logic pin_rise;
    logic pin_stable;
    logic trig;
    logic start_ok;
    logic conv_end;
    logic [7:0] res_hi;
    logic [7:0] res_lo;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ========================================================
    // Conversion clock divider
    acs_sar_tick u_tick (
        .clk(CLK_SYS),
        .rst(RST),
        .run(r_ff.en),
        .div(r_ff.cfg[DIV_LSB +: DIV_W]),
        .tick(tick)
    );

    // ========================================================
    // Trigger and bus decode
    assign busy = (r_ff.st != ST_IDLE);
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign wr_en = APB_REQ.psel && APB_REQ.penable && r_ff.pready && APB_REQ.pwrite;
    assign pin_stable = (r_ff.pin_sync[1] == r_ff.pin_sync[2]);
    assign pin_rise = pin_stable && r_ff.pin_sync[2] && !r_ff.pin_q;

    always_comb
    begin
        case (r_ff.cm)
            CM_SOFTWARE: trig = wr_en && addr_is(APB_REQ.paddr, ADDR_CONV_CONTROL)
                && APB_REQ.pwdata[CTL_BUSY_BIT];
            CM_TIMER3: trig = TMR3_OVF;
            CM_EXT_PIN: trig = pin_rise;
            CM_TIMER2: trig = TMR2_OVF;
            default: trig = 1'b0;
        endcase
    end

    // Starts need an enabled idle converter and the rate window elapsed
    assign start_ok = trig && r_ff.en && !busy && (r_ff.rate_cnt == '0);
    assign conv_end = (r_ff.st == ST_CONVERT) && tick && (r_ff.cnv_cnt == SAR_CONV_CLKS - 4'h1);

    // Justified views of the stored result
    always_comb
    begin
        if (r_ff.ljst)
        begin
            res_hi = r_ff.result[RES_W-1 -: 8];
            res_lo = {r_ff.result[JUST_PAD-1:0], {JUST_PAD{1'b0}}};
        end
        else
        begin
            res_hi = {{JUST_PAD{1'b0}}, r_ff.result[RES_W-1:8]};
            res_lo = r_ff.result[7:0];
        end
    end

    // ========================================================
    // Next state
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.sar_tick = tick;
        nxt_r.pin_sync = {r_ff.pin_sync[1:0], EXT_CONV_START};
        if (pin_stable)
        begin
            nxt_r.pin_q = r_ff.pin_sync[2];
        end
        if (r_ff.rate_cnt != '0)
        begin
            nxt_r.rate_cnt = r_ff.rate_cnt - 10'h1;
        end

        // Register writes
        if (wr_en)
        begin
            if (addr_is(APB_REQ.paddr, ADDR_HV_AMP_CONTROL))
            begin
                nxt_r.hv_ctrl[HV_EN_BIT] = APB_REQ.pwdata[HV_EN_BIT];
                nxt_r.hv_ctrl[HV_GAIN_W-1:0] = APB_REQ.pwdata[HV_GAIN_W-1:0];
            end
            if (addr_is(APB_REQ.paddr, ADDR_CONV_CONFIG))
            begin
                nxt_r.cfg = APB_REQ.pwdata[7:0];
            end
            if (addr_is(APB_REQ.paddr, ADDR_CONV_CONTROL))
            begin
                nxt_r.en = APB_REQ.pwdata[CTL_EN_BIT];
                nxt_r.tm = APB_REQ.pwdata[CTL_TM_BIT];
                nxt_r.cm = APB_REQ.pwdata[CTL_CM_LSB +: 2];
                nxt_r.ljst = APB_REQ.pwdata[CTL_LJST_BIT];
                if (!APB_REQ.pwdata[CTL_DONE_BIT])
                begin
                    nxt_r.done = 1'b0;
                end
            end
            if (addr_is(APB_REQ.paddr, ADDR_IRQ_CLEAR) && APB_REQ.pwdata[IRQ_DONE_BIT])
            begin
                nxt_r.irq_stat = 1'b0;
            end
            if (addr_is(APB_REQ.paddr, ADDR_IRQ_ENABLE))
            begin
                nxt_r.irq_en = APB_REQ.pwdata[IRQ_DONE_BIT];
            end
        end

        // Sequencer
        case (r_ff.st)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    nxt_r.rate_cnt = RATE_LOAD;
                    nxt_r.trk_cnt = '0;
                    nxt_r.cnv_cnt = '0;
                    // Pin mode already tracked while the pin was low
                    if (r_ff.tm && (r_ff.cm != CM_EXT_PIN))
                    begin
                        nxt_r.st = ST_TRACK;
                    end
                    else
                    begin
                        nxt_r.st = ST_CONVERT;
                    end
                end
            end
            ST_TRACK:
            begin
                if (tick)
                begin
                    nxt_r.trk_cnt = r_ff.trk_cnt + 2'h1;
                    if (r_ff.trk_cnt == LP_TRACK_CLKS - 2'h1)
                    begin
                        nxt_r.st = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (tick)
                begin
                    nxt_r.cnv_cnt = r_ff.cnv_cnt + 4'h1;
                end
                if (conv_end)
                begin
                    nxt_r.result = SAR_RESULT;
                    nxt_r.st = ST_IDLE;
                    nxt_r.done = 1'b1;
                    nxt_r.irq_stat = 1'b1;
                end
            end
            default: nxt_r.st = ST_IDLE;
        endcase
        // Disabling the converter aborts any conversion
        if (!r_ff.en)
        begin
            nxt_r.st = ST_IDLE;
        end

        // Track-and-hold control
        if (CHIP_SLEEP || !nxt_r.en)
        begin
            nxt_r.track = 1'b0;
        end
        else if (nxt_r.st == ST_TRACK)
        begin
            nxt_r.track = 1'b1;
        end
        else if (nxt_r.st == ST_IDLE)
        begin
            if (!nxt_r.tm)
            begin
                nxt_r.track = 1'b1;
            end
            else
            begin
                nxt_r.track = (nxt_r.cm == CM_EXT_PIN) && !r_ff.pin_q;
            end
        end
        else
        begin
            nxt_r.track = 1'b0;
        end
        nxt_r.convert = (nxt_r.st == ST_CONVERT);
        nxt_r.irq = nxt_r.irq_stat && nxt_r.irq_en;

        // APB answer prepared in the setup cycle
        nxt_r.pready = setup;
        nxt_r.pslverr = 1'b0;
        nxt_r.prdata = '0;
        if (setup)
        begin
            case (APB_REQ.paddr)
                ADDR_HV_AMP_CONTROL: nxt_r.prdata[7:0] = r_ff.hv_ctrl;
                ADDR_CONV_CONFIG: nxt_r.prdata[7:0] = r_ff.cfg;
                ADDR_CONV_CONTROL: nxt_r.prdata[7:0] = {r_ff.en, r_ff.tm, r_ff.done, busy,
                    r_ff.cm, 1'b0, r_ff.ljst};
                ADDR_RESULT_HIGH: nxt_r.prdata[7:0] = res_hi;
                ADDR_RESULT_LOW: nxt_r.prdata[7:0] = res_lo;
                ADDR_IRQ_STATUS: nxt_r.prdata[IRQ_DONE_BIT] = r_ff.irq_stat;
                ADDR_IRQ_CLEAR: nxt_r.prdata = '0;
                ADDR_IRQ_ENABLE: nxt_r.prdata[IRQ_DONE_BIT] = r_ff.irq_en;
                default: nxt_r.pslverr = 1'b1;
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            r_ff <= '0;
            r_ff.hv_ctrl <= HV_AMP_RESET;
            r_ff.cfg <= CONV_CONFIG_RESET;
            r_ff.st <= ST_IDLE;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign PRDATA = r_ff.prdata;
    assign PREADY = r_ff.pready;
    assign PSLVERR = r_ff.pslverr;
    assign HV_DIFF_AMP_EN = r_ff.hv_ctrl[HV_EN_BIT];
    assign HV_GAIN_SEL = r_ff.hv_ctrl[HV_GAIN_W-1:0];
    assign PGA_GAIN = r_ff.cfg[PGA_W-1:0];
    assign SAR_POWER = r_ff.en;
    assign SAR_TRACK = r_ff.track;
    assign SAR_CONVERT = r_ff.convert;
    assign SAR_CLK_TICK = r_ff.sar_tick;
    assign IRQ = r_ff.irq;

    // ========================================================
    // Checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    chk_hv_enable_bit: assert property (
        wr_en && addr_is(APB_REQ.paddr, ADDR_HV_AMP_CONTROL)
        |=> HV_DIFF_AMP_EN == $past(APB_REQ.pwdata[HV_EN_BIT]))
        else $error("amplifier enable not updated");
    chk_hv_gain_field: assert property (
        wr_en && addr_is(APB_REQ.paddr, ADDR_HV_AMP_CONTROL)
        |=> HV_GAIN_SEL == $past(APB_REQ.pwdata[HV_GAIN_W-1:0]))
        else $error("amplifier gain not updated");
    chk_rate_window: assert property (
        $rose(busy) |-> r_ff.rate_cnt == RATE_LOAD)
        else $error("conversion started inside rate window");
    chk_sw_start: assert property (
        r_ff.cm == CM_SOFTWARE && trig && r_ff.en && !busy && r_ff.rate_cnt == '0
        |=> busy)
        else $error("software start ignored");
    chk_timer3_start: assert property (
        r_ff.cm == CM_TIMER3 && TMR3_OVF && r_ff.en && !busy && r_ff.rate_cnt == '0
        |=> busy)
        else $error("timer 3 start ignored");
    chk_pin_start: assert property (
        r_ff.cm == CM_EXT_PIN && pin_rise && r_ff.en && !busy && r_ff.rate_cnt == '0
        |=> busy && SAR_CONVERT)
        else $error("pin start ignored");
    chk_timer2_start: assert property (
        r_ff.cm == CM_TIMER2 && TMR2_OVF && r_ff.en && !busy && r_ff.rate_cnt == '0
        |=> busy)
        else $error("timer 2 start ignored");
    chk_done_on_fall: assert property (
        $fell(busy) && r_ff.en |-> r_ff.done && r_ff.irq_stat && IRQ == r_ff.irq_en)
        else $error("done flag not set at busy fall");
    chk_idle_tracking: assert property (
        !busy && !r_ff.tm && r_ff.en && !CHIP_SLEEP && !start_ok
        && !(wr_en && addr_is(APB_REQ.paddr, ADDR_CONV_CONTROL)) |=> SAR_TRACK)
        else $error("idle converter not tracking");
    chk_lp_track_first: assert property (
        $rose(busy) && r_ff.st == ST_TRACK |-> !SAR_CONVERT ##1 !SAR_CONVERT)
        else $error("low-power tracking period skipped");
    chk_sleep_no_track: assert property (
        CHIP_SLEEP |=> !SAR_TRACK)
        else $error("tracking during sleep");
    chk_ignore_busy: assert property (
        r_ff.st == ST_CONVERT && trig && !conv_end && r_ff.en |=> r_ff.st == ST_CONVERT)
        else $error("trigger disturbed conversion");

    cov_sw_conv: cover property ($fell(busy) && r_ff.cm == CM_SOFTWARE);
    cov_lp_conv: cover property (r_ff.st == ST_TRACK ##1 r_ff.st == ST_TRACK);
    cov_pin_conv: cover property ($fell(busy) && r_ff.cm == CM_EXT_PIN);
endmodule
`default_nettype wire

/* File: acs_sar_model.sv */
/*
 * Behavioural model of the converter core behind the sequencer.
 * Assumes track and convert levels from the sequencer on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_sar_model
    import acs_pkg::*;
(
    input wire logic clk,                  // System clock
    input wire logic rst,                  // Async reset, high
    input wire logic track,                // Track-and-hold tracking
    input wire logic convert,              // Converting
    input wire logic [RES_W-1:0] code,     // Level seen at the input
    output logic [RES_W-1:0] result        // Result bus to the sequencer
);
    logic [RES_W-1:0] held_ff;

    // ========================================
    // Sample only while tracking
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            held_ff <= '0;
        else if (track && !convert)
            held_ff <= code;
    end

    // Bus not valid outside a conversion
    assign result = convert ? held_ff : ~held_ff;
endmodule
`default_nettype wire

/* File: tb_adc_conversion_sequencer.sv */
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes acs_pkg, acs_sequencer and acs_sar_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
    import acs_pkg::*;
    localparam int DIV = 3;
    localparam int TCK = DIV + 1;
    logic clk_sys, rst, pready, pslverr, tmr3, tmr2, ext_pin, sleep;
    logic hv_en, sar_power, track, convert, tick, irq;
    acs_apb_req_type req;
    logic [31:0] prdata;
    logic [RES_W-1:0] sar_result, code;
    logic [HV_GAIN_W-1:0] hv_gain;
    logic [PGA_W-1:0] gain_stage;
    int fail_count, num_checks, cycles;

    acs_sequencer DUT (.CLK_SYS(clk_sys), .RST(rst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TMR3_OVF(tmr3), .TMR2_OVF(tmr2), .EXT_CONV_START(ext_pin), .CHIP_SLEEP(sleep),
        .SAR_RESULT(sar_result), .HV_DIFF_AMP_EN(hv_en), .HV_GAIN_SEL(hv_gain), .PGA_GAIN(gain_stage),
        .SAR_POWER(sar_power), .SAR_TRACK(track), .SAR_CONVERT(convert), .SAR_CLK_TICK(tick), .IRQ(irq));
    acs_sar_model core (.clk(clk_sys), .rst(rst), .track(track), .convert(convert), .code(code),
        .result(sar_result));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ========================================
    // Checking and bus tasks
    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req <= '0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, x, r);
    endtask

    // Fire the timer or pin trigger of mode m, count tracking cycles, then converting cycles
    task automatic run_conv(input logic [1:0] m, output int trk, output int cnv);
        int n;
        n = 0;
        trk = 0;
        cnv = 0;
        while (convert !== 1'b1 && n < 300)
        begin
            tmr3 <= (n == 0) && (m == CM_TIMER3);
            tmr2 <= (n == 0) && (m == CM_TIMER2);
            ext_pin <= !((m == CM_EXT_PIN) && (n < 8));
            @(posedge clk_sys);
            n++;
            if (track === 1'b1)
                trk++;
        end
        while (convert === 1'b1 && cnv < 300)
        begin
            tmr3 <= (cnv == 10) && (m == CM_TIMER3);
            tmr2 <= (cnv == 10) && (m == CM_TIMER2);
            @(posedge clk_sys);
            cnv++;
        end
        tmr3 <= 1'b0;
        tmr2 <= 1'b0;
    endtask

    // ========================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(ADDR_HV_AMP_CONTROL, {24'h0, HV_AMP_RESET}, "hv reset");
        rd(ADDR_CONV_CONFIG, {24'h0, CONV_CONFIG_RESET}, "config reset");
        rd(ADDR_CONV_CONTROL, 32'h0, "control reset");
        chk("power reset", 32'h0, sar_power);
        wr(ADDR_CONV_CONFIG, 32'h05);
        chk("pga gain", 32'h5, gain_stage);
        wr(ADDR_HV_AMP_CONTROL, 32'hffff_ffff);
        rd(ADDR_HV_AMP_CONTROL, 32'h87, "hv readback");
        chk("hv enable", 32'h1, hv_en);
        chk("hv gain max", 32'h7, hv_gain);
        wr(ADDR_HV_AMP_CONTROL, 32'h05);
        chk("hv disable", 32'h0, hv_en);
        chk("hv gain", 32'h5, hv_gain);
        apb(1'b1, 8'h20, 32'hffff_ffff, r, e);
        chk("unmapped error", 32'h1, e);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped data", 32'h0, r);
    endtask

    task automatic t_soft();
        logic [31:0] r;
        logic e;
        int g, k;
        wr(ADDR_IRQ_ENABLE, 32'h1);
        wr(ADDR_CONV_CONFIG, {24'h0, 5'(DIV), 3'h0});
        wr(ADDR_CONV_CONTROL, 32'h80);
        chk("converter power", 32'h1, sar_power);
        chk("pga cleared", 32'h0, gain_stage);
        g = 0;
        k = 0;
        while (tick !== 1'b1 && k < 100)
        begin
            @(posedge clk_sys);
            k++;
        end
        do
        begin
            @(posedge clk_sys);
            g++;
        end
        while (tick !== 1'b1 && g < 100);
        chk("tick gap", TCK, g);
        code <= 12'ha5c;
        wr(ADDR_CONV_CONTROL, 32'h80);
        wr(ADDR_CONV_CONTROL, 32'h90);
        rd(ADDR_CONV_CONTROL, 32'h90, "busy during");
        k = 0;
        do
        begin
            apb(1'b0, ADDR_CONV_CONTROL, 32'h0, r, e);
            k++;
        end
        while (r[CTL_DONE_BIT] !== 1'b1 && k < 50);
        chk("done and idle", 32'ha0, r);
        @(posedge clk_sys);
        chk("irq raised", 32'h1, irq);
        rd(ADDR_IRQ_STATUS, 32'h1, "status");
        rd(ADDR_RESULT_HIGH, 32'h00a, "right high");
        rd(ADDR_RESULT_LOW, 32'h05c, "right low");
        wr(ADDR_CONV_CONTROL, 32'h81);
        rd(ADDR_RESULT_HIGH, 32'h0a5, "left high");
        rd(ADDR_RESULT_LOW, 32'h0c0, "left low");
        wr(ADDR_IRQ_ENABLE, 32'h0);
        @(posedge clk_sys);
        chk("irq masked", 32'h0, irq);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        wr(ADDR_IRQ_CLEAR, 32'h1);
        rd(ADDR_IRQ_CLEAR, 32'h0, "clear reads zero");
        chk("irq cleared", 32'h0, irq);
        rd(ADDR_IRQ_STATUS, 32'h0, "status cleared");
    endtask

    task automatic t_sources();
        acs_start_mode_type md [6] = '{CM_TIMER3, CM_TIMER2, CM_EXT_PIN, CM_EXT_PIN, CM_SOFTWARE, CM_SOFTWARE};
        logic lp [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [7:0] cv;
        int trk, cnv, lo, hi;
        for (int i = 0; i < 6; i++)
        begin
            repeat (1000) @(posedge clk_sys);
            cv = {1'b1, lp[i], 2'b00, md[i], 2'b00};
            wr(ADDR_CONV_CONTROL, {24'h0, cv});
            tmr3 <= md[i] != CM_TIMER3;
            tmr2 <= md[i] != CM_TIMER2;
            ext_pin <= md[i] == CM_EXT_PIN;
            @(posedge clk_sys);
            tmr3 <= 1'b0;
            tmr2 <= 1'b0;
            repeat (6) @(posedge clk_sys);
            ext_pin <= 1'b1;
            repeat (8) @(posedge clk_sys);
            rd(ADDR_CONV_CONTROL, {24'h0, cv}, "stray start");
            chk("idle tracking", {31'h0, !lp[i]}, track);
            if (!lp[i])
            begin
                sleep <= 1'b1;
                repeat (3) @(posedge clk_sys);
                chk("sleep tracking", 32'h0, track);
                sleep <= 1'b0;
            end
            if (md[i] == CM_SOFTWARE)
                wr(ADDR_CONV_CONTROL, {24'h0, cv | 8'h10});
            run_conv(md[i], trk, cnv);
            chk("convert cycles", 32'h1, cnv >= 12 * TCK && cnv <= 13 * TCK + 1);
            lo = (md[i] == CM_EXT_PIN) ? 6 : (lp[i] ? 3 * TCK - 5 : 0);
            hi = (md[i] == CM_EXT_PIN) ? 14 : (lp[i] ? 3 * TCK + 1 : 4);
            chk("track cycles", 32'h1, trk >= lo && trk <= hi);
            repeat (40) @(posedge clk_sys);
            chk("no restart", 32'h0, convert);
        end
    endtask

    // ========================================
    // Main sequence and hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        rst = 1'b1;
        req = '0;
        tmr3 = 1'b0;
        tmr2 = 1'b0;
        ext_pin = 1'b1;
        sleep = 1'b0;
        code = '0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_soft();
        t_sources();
        tally_and_finish();
    end
endmodule
`default_nettype wire
